// file: aux_switch_route_decode.sv
// What this block does
// - Decode mode 00 quad, 01 dual, 10 single
// - Mode write of 11 keeps previous mode
// - Quad: low pick bits choose whole group
// - Dual: bit2 picks A/C or B/D pair
// - Single: four pick bits choose one channel
// - Terminations off while termination bit clear
// - Switch disabled leaves all lines unconnected
// - Pulsed channel terminations drop 100 ms on switch
`timescale 1ns/1ps
`default_nettype none

module aux_switch_route_decode #(
    parameter int PULSE_CYCLES = int'(aux_switch_pkg::PULSE_CYCLES)
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register write port
    input  wire logic        modes_wr,
    input  wire logic        rxset_wr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [15:0] term_pulse_sel,
    // Register read back
    output logic      [7:0]  modes_rd,
    output logic      [7:0]  rxset_rd,
    // Switch controls: conn[line*16 + channel], channel A0..D3 = 0..15
    output logic      [63:0] route_conn,
    // Per input channel termination connect, same channel order
    output logic      [15:0] term_connect
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Zero would leave the pulse timer unable to open a gap
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("PULSE_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic       en_reg;
    logic [1:0] mode_reg;
    logic [3:0] pick_reg;
    logic       term_on_reg;
    logic [31:0] pulse_cnt_reg;
    logic [31:0] pulse_cnt_next;
    wire  [15:0] pulse_by_ch;
    wire  [15:0] term_next;
    wire  [63:0] route_next;

    wire  [1:0] wr_mode     = wr_data[aux_switch_pkg::MODES_MODE_LSB +: 2];
    wire        mode_legal  = wr_mode != aux_switch_pkg::MODE_ILLEGAL;
    wire  [1:0] mode_next   = (modes_wr && mode_legal) ? wr_mode : mode_reg;
    wire        switch_evt  = modes_wr &&
                              ((wr_data[aux_switch_pkg::MODES_PICK_LSB +: 4] != pick_reg) ||
                               (mode_next != mode_reg));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_reg   <= aux_switch_pkg::MODES_RESET[aux_switch_pkg::MODES_EN_BIT];
            mode_reg <= aux_switch_pkg::MODES_RESET[aux_switch_pkg::MODES_MODE_LSB +: 2];
            pick_reg <= aux_switch_pkg::MODES_RESET[aux_switch_pkg::MODES_PICK_LSB +: 4];
        end else if (modes_wr) begin
            en_reg   <= wr_data[aux_switch_pkg::MODES_EN_BIT];
            mode_reg <= mode_next;
            pick_reg <= wr_data[aux_switch_pkg::MODES_PICK_LSB +: 4];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            term_on_reg <= aux_switch_pkg::RXSET_RESET[aux_switch_pkg::RXSET_TERM_BIT];
        end else if (rxset_wr) begin
            term_on_reg <= wr_data[aux_switch_pkg::RXSET_TERM_BIT];
        end
    end

    // ------------------------------------------------------------
    // Termination pulse timer
    // ------------------------------------------------------------
    // Restarts on every source switch, so back to back switches extend the gap
    assign pulse_cnt_next = switch_evt ? 32'(PULSE_CYCLES) :
                            (pulse_cnt_reg != 32'h0000_0000) ? pulse_cnt_reg - 32'h0000_0001 : pulse_cnt_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt_reg <= 32'h0000_0000;
        end else begin
            pulse_cnt_reg <= pulse_cnt_next;
        end
    end

    wire pulsing = pulse_cnt_reg != 32'h0000_0000;

    // Pulse select bit order differs from channel order
    localparam logic [63:0] PULSE_MAP = 64'hCDEF_89AB_3210_7654;

    genvar ch;
    generate
        for (ch = 0; ch < 16; ch++) begin : g_term
            wire [3:0] sel_bit = 4'(PULSE_MAP >> (4 * ch));
            assign pulse_by_ch[ch] = term_pulse_sel[sel_bit];
        end
    endgenerate

    // Pulse only gaps a termination that is switched on
    assign term_next = term_on_reg ? ~(pulse_by_ch & {16{pulsing}}) : 16'h0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            term_connect <= 16'h0000;
        end else begin
            term_connect <= term_next;
        end
    end

    // ------------------------------------------------------------
    // Route decode
    // ------------------------------------------------------------
    // Channel index = group*4 + lane; A=0, B=1, C=2, D=3
    genvar ln;
    generate
        for (ln = 0; ln < 4; ln++) begin : g_line
            logic [3:0] src;
            logic       used;
            always_comb begin
                src  = 4'h0;
                used = 1'b0;
                case (mode_reg)
                    aux_switch_pkg::MODE_QUAD: begin
                        src  = {pick_reg[1:0], 2'(ln)};
                        used = 1'b1;
                    end
                    aux_switch_pkg::MODE_DUAL: begin
                        // Line 0 from A/B, line 2 from C/D; lines 1 and 3 unused; lane from pick bits 1:0
                        src  = {(ln >= 2), pick_reg[2], pick_reg[1:0]};
                        used = (ln == 0) || (ln == 2);
                    end
                    aux_switch_pkg::MODE_SINGLE: begin
                        src  = pick_reg;
                        used = (ln == 0);
                    end
                    default: begin
                        src  = 4'h0;
                        used = 1'b0;
                    end
                endcase
            end
            assign route_next[ln*16 +: 16] = (en_reg && used) ? (16'h0001 << src) : 16'h0000;
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            route_conn <= 64'h0000_0000_0000_0000;
        end else begin
            route_conn <= route_next;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    assign modes_rd = {1'b0, en_reg, mode_reg, pick_reg} & aux_switch_pkg::MODES_READ_MASK;
    assign rxset_rd = {7'h00, term_on_reg};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_illegal_mode_kept: assert property (@(posedge clk) disable iff (!resetn)
        (modes_wr && wr_mode == aux_switch_pkg::MODE_ILLEGAL) |=> (mode_reg == $past(mode_reg)))
        else $error("illegal mode changed setting");
    a_disabled_open: assert property (@(posedge clk) disable iff (!resetn)
        !en_reg |=> route_conn == 64'h0)
        else $error("route closed while disabled");
    a_term_off_open: assert property (@(posedge clk) disable iff (!resetn)
        !term_on_reg |=> term_connect == 16'h0000)
        else $error("termination on while off");
    a_quad_group: assert property (@(posedge clk) disable iff (!resetn)
        (en_reg && mode_reg == aux_switch_pkg::MODE_QUAD) |=>
        route_conn[15:0] == (16'h0001 << {$past(pick_reg[1:0]), 2'b00}))
        else $error("quad routing wrong");
    a_single_one: assert property (@(posedge clk) disable iff (!resetn)
        (en_reg && mode_reg == aux_switch_pkg::MODE_SINGLE) |=>
        route_conn == {48'h0, 16'h0001 << $past(pick_reg)})
        else $error("single routing wrong");
    a_dual_pair: assert property (@(posedge clk) disable iff (!resetn)
        (en_reg && mode_reg == aux_switch_pkg::MODE_DUAL) |=>
        route_conn[47:32] == (16'h0001 << {1'b1, $past(pick_reg[2:0])}))
        else $error("dual routing wrong");
    a_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
        switch_evt |=> pulse_cnt_reg == 32'(PULSE_CYCLES))
        else $error("pulse timer not started");
    a_mode_legal: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg != aux_switch_pkg::MODE_ILLEGAL)
        else $error("illegal mode held");
    a_quad_top: assert property (@(posedge clk) disable iff (!resetn)
        (en_reg && mode_reg == aux_switch_pkg::MODE_QUAD) |=>
        route_conn[63:48] == (16'h0001 << {$past(pick_reg[1:0]), 2'b11}))
        else $error("quad top line wrong");
    a_dual_low: assert property (@(posedge clk) disable iff (!resetn)
        (en_reg && mode_reg == aux_switch_pkg::MODE_DUAL) |=>
        route_conn[15:0] == (16'h0001 << {1'b0, $past(pick_reg[2:0])}))
        else $error("dual low pair wrong");
    a_pulse_gap: assert property (@(posedge clk) disable iff (!resetn)
        (term_on_reg && pulsing) |=> term_connect == ~$past(pulse_by_ch))
        else $error("pulse gap pattern wrong");
    a_term_held: assert property (@(posedge clk) disable iff (!resetn)
        (term_on_reg && !pulsing) |=> term_connect == 16'hffff)
        else $error("termination dropped without switch");
    a_pulse_bound: assert property (@(posedge clk) disable iff (!resetn)
        pulse_cnt_reg <= 32'(PULSE_CYCLES))
        else $error("pulse timer out of range");
    a_pulse_count: assert property (@(posedge clk) disable iff (!resetn)
        (!switch_evt && pulsing) |=> pulse_cnt_reg == $past(pulse_cnt_reg) - 32'h0000_0001)
        else $error("pulse timer not counting down");

endmodule

`default_nettype wire

// file: aux_switch_pkg.sv
`default_nettype none

package aux_switch_pkg;

    // ------------------------------------------------------------
    // Bundling modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_QUAD    = 2'h0;
    localparam logic [1:0] MODE_DUAL    = 2'h1;
    localparam logic [1:0] MODE_SINGLE  = 2'h2;
    localparam logic [1:0] MODE_ILLEGAL = 2'h3;

    // ------------------------------------------------------------
    // Auxiliary switch modes register fields
    // ------------------------------------------------------------
    localparam int MODES_EN_BIT    = 6;
    localparam int MODES_MODE_LSB  = 4;
    localparam int MODES_PICK_LSB  = 0;
    localparam logic [7:0] MODES_RESET     = 8'h40;
    localparam logic [7:0] MODES_READ_MASK = 8'h7F;

    // ------------------------------------------------------------
    // Receiver settings register fields
    // ------------------------------------------------------------
    localparam int RXSET_TERM_BIT = 0;
    localparam logic [7:0] RXSET_RESET     = 8'h01;
    localparam logic [7:0] RXSET_READ_MASK = 8'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ        = 25000000;
    localparam longint PULSE_TIME_MS = 100;
    localparam longint PULSE_CYCLES  = (PULSE_TIME_MS * CLK_HZ) / 1000;

endpackage

`default_nettype wire

// file: aux_host.sv
`timescale 1ns/1ps
`default_nettype none
module aux_host (
    // Clock
    input  wire logic       clk,
    // Register writes
    output var  logic       modes_wr,
    output var  logic       rxset_wr,
    output var  logic [7:0] wr_data
);
    initial begin
        modes_wr = 1'b0;
        rxset_wr = 1'b0;
        wr_data  = 8'h00;
    end
    // Strobe spans exactly one rising edge, so no double write
    task automatic wr(input logic rx, input logic [7:0] d);
        @(negedge clk);
        modes_wr <= !rx;
        rxset_wr <= rx;
        wr_data  <= d;
        @(negedge clk);
        modes_wr <= 1'b0;
        rxset_wr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: aux_switch_route_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aux_switch_route_decode_tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        modes_wr;
    logic        rxset_wr;
    logic [7:0]  wr_data;
    logic [7:0]  modes_rd;
    logic [7:0]  rxset_rd;
    logic [15:0] term_pulse_sel = 16'h0000;
    logic [15:0] term_connect;
    logic [63:0] route_conn;
    int          mismatches = 0;
    int          n_checks = 0;
    always #20 clk = ~clk;
    aux_host i_aux_host (.clk(clk), .modes_wr(modes_wr), .rxset_wr(rxset_wr), .wr_data(wr_data));
    aux_switch_route_decode #(.PULSE_CYCLES(8)) i_aux_switch_route_decode (.clk(clk), .resetn(resetn),
        .modes_wr(modes_wr), .rxset_wr(rxset_wr), .wr_data(wr_data), .term_pulse_sel(term_pulse_sel),
        .modes_rd(modes_rd), .rxset_rd(rxset_rd), .route_conn(route_conn), .term_connect(term_connect));
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Dual mode uses lines 0 and 2 only
    function automatic logic [63:0] er(input logic [1:0] m, input logic en, input logic [3:0] p);
        logic [63:0] r;
        r = 64'h0000_0000_0000_0000;
        if (en && m == aux_switch_pkg::MODE_QUAD)
            for (int l = 0; l < 4; l++) r[l * 16 + int'(p[1:0]) * 4 + l] = 1'b1;
        if (en && m == aux_switch_pkg::MODE_DUAL) begin
            r[int'(p[2]) * 4 + int'(p[1:0])] = 1'b1;
            r[32 + (int'(p[2]) + 2) * 4 + int'(p[1:0])] = 1'b1;
        end
        if (en && m == aux_switch_pkg::MODE_SINGLE)
            r[p] = 1'b1;
        return r;
    endfunction
    // Outputs settle one edge after the write edge
    task automatic wm(input logic rx, input logic [7:0] d);
        i_aux_host.wr(rx, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("modes_rd", modes_rd, aux_switch_pkg::MODES_RESET);
        chk("rxset_rd", rxset_rd, aux_switch_pkg::RXSET_RESET);
        chk("route", route_conn, er(2'h0, 1'b1, 4'h0));
        chk("term", term_connect, 16'hffff);
    endtask
    // Reset in mid-run brings back the power-up routing
    task automatic t_rerst();
        resetn = 1'b0;
        @(negedge clk);
        chk("modes_rd", modes_rd, aux_switch_pkg::MODES_RESET);
        chk("rxset_rd", rxset_rd, aux_switch_pkg::RXSET_RESET);
        resetn = 1'b1;
        @(negedge clk);
        chk("route", route_conn, er(2'h0, 1'b1, 4'h0));
        chk("term", term_connect, 16'hffff);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++)
            for (int p = 0; p < 16; p++) begin
                wm(1'b0, {2'b01, m[1:0], p[3:0]});
                chk("modes_rd", modes_rd, {2'b01, m[1:0], p[3:0]});
                chk("route", route_conn, er(m[1:0], 1'b1, p[3:0]));
            end
    endtask
    task automatic t_illegal();
        wm(1'b0, 8'h62);
        wm(1'b0, 8'h75);
        chk("modes_rd", modes_rd, 8'h65);
        chk("route", route_conn, er(2'h2, 1'b1, 4'h5));
    endtask
    task automatic t_enable();
        wm(1'b0, 8'h1a);
        chk("route", route_conn, 64'h0000_0000_0000_0000);
        wm(1'b0, 8'h5a);
        chk("route", route_conn, er(2'h1, 1'b1, 4'ha));
    endtask
    task automatic t_term();
        wm(1'b1, 8'h00);
        chk("rxset_rd", rxset_rd, 8'h00);
        chk("term", term_connect, 16'h0000);
        wm(1'b1, 8'h01);
        chk("term", term_connect, 16'hffff);
    endtask
    // Pulse bits 4, 8 map to channels A0, C3 (0, 11); then bits 0, 12 to B0, D3 (4, 15)
    task automatic t_pulse();
        term_pulse_sel = 16'h0110;
        wm(1'b0, 8'h43);
        chk("term", term_connect, 16'hf7fe);
        repeat (12) @(negedge clk);
        chk("term", term_connect, 16'hffff);
        term_pulse_sel = 16'h1001;
        wm(1'b0, 8'h44);
        chk("term", term_connect, 16'h7fef);
        repeat (12) @(negedge clk);
        chk("term", term_connect, 16'hffff);
        wm(1'b0, 8'h44);
        chk("term", term_connect, 16'hffff);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        t_reset();
        t_modes();
        t_illegal();
        t_enable();
        t_term();
        t_pulse();
        t_rerst();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
